// ---- include/tlsc_pkg.sv ----
// constants shared by the launch and stop configuration block
package tlsc_pkg;

  // ----------------------------------------------------------------
  // serial opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0]  OPC_WR_PULSE   = 8'h38;
  localparam logic [7:0]  OPC_RD_PULSE   = 8'hB8;
  localparam logic [7:0]  OPC_WR_STOP    = 8'h39;
  localparam logic [7:0]  OPC_RD_STOP    = 8'hB9;

  // ----------------------------------------------------------------
  // reset values and writable bit masks
  // ----------------------------------------------------------------
  localparam logic [15:0] PULSE_CFG_RST  = 16'h0000;
  localparam logic [15:0] STOP_CFG_RST   = 16'h0000;
  localparam logic [15:0] PULSE_CFG_MASK = 16'hFFF8;  // bits 2:0 reserved
  localparam logic [15:0] STOP_CFG_MASK  = 16'hFFF7;  // bit 3 reserved

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PCOUNT_LSB  = 8;   // launch_pulse_count 15:8
  localparam int PCOUNT_MSB  = 15;
  localparam int FDIV_LSB    = 4;   // launch_freq_divider 7:4
  localparam int FDIV_MSB    = 7;
  localparam int POL_BIT     = 3;   // stop_edge_polarity
  localparam int HITS_LSB    = 13;  // stop hits 15:13
  localparam int HITS_MSB    = 15;
  localparam int WAVE_LSB    = 7;   // second_ref_wave_select 12:7
  localparam int WAVE_MSB    = 12;
  localparam int CYC_LSB     = 4;   // measure_cycle_setting 6:4
  localparam int CYC_MSB     = 6;
  localparam int TMO_LSB     = 0;   // measure_timeout_setting 2:0
  localparam int TMO_MSB     = 2;

  // ----------------------------------------------------------------
  // limits
  // ----------------------------------------------------------------
  localparam logic [7:0]  MAX_PULSES     = 8'h7F;    // 127
  localparam logic [3:0]  MAX_HITS       = 4'h6;
  localparam logic [5:0]  MIN_WAVE       = 6'h02;

  // ----------------------------------------------------------------
  // timing: core clock -> internal reference -> 2 MHz launch base
  // ----------------------------------------------------------------
  localparam int CORE_CLK_HZ    = 40_000_000;
  localparam int LAUNCH_BASE_HZ = 2_000_000;
  localparam int BASE_REF_DIV   = 2;
  localparam int REF_CLK_HZ     = LAUNCH_BASE_HZ * BASE_REF_DIV;
  localparam int REF_TICK_CYC   = CORE_CLK_HZ / REF_CLK_HZ;  // 10 cycles

endpackage

// ---- rtl/tlsc_launcher.sv ----
// pulse launcher: burst of pulses at a programmable fraction of 2 MHz
`timescale 1ns/100ps
`default_nettype none
module tlsc_launcher
  import tlsc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic [7:0] pulse_count,
  input  wire logic [3:0] freq_div,
  output logic            launch_out,
  output logic            launch_busy,
  output logic            launch_done
);

  typedef enum logic [0:0] {
    TLSC_L_IDLE = 1'b0,
    TLSC_L_RUN  = 1'b1
  } tlsc_lstate_type;

  tlsc_lstate_type state_ff;
  logic [3:0]      ref_cnt_ff;
  logic            base_half_ff;
  logic            base_tick;
  logic [3:0]      phase_ff;
  logic [7:0]      left_ff;
  logic [3:0]      div_ff;
  logic            out_ff;
  logic            done_ff;
  logic [7:0]      eff_count;

  // ----------------------------------------------------------------
  // reference tick, then divide by two for the 2 MHz base
  // ----------------------------------------------------------------
  // free running, so the first pulse of a burst waits for the next base tick after start
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ref_cnt_ff   <= 4'h0;
      base_half_ff <= 1'b0;
    end else if (ref_cnt_ff == 4'(REF_TICK_CYC - 1)) begin
      ref_cnt_ff   <= 4'h0;
      base_half_ff <= ~base_half_ff;
    end else begin
      ref_cnt_ff   <= ref_cnt_ff + 4'h1;
    end
  end

  assign base_tick = (ref_cnt_ff == 4'(REF_TICK_CYC - 1)) && base_half_ff;

  // clamp the programmed count to what the launcher can drive
  assign eff_count = (pulse_count > MAX_PULSES) ? MAX_PULSES : pulse_count;

  // ----------------------------------------------------------------
  // burst sequencer
  // ----------------------------------------------------------------
  // one launch period is freq_div+1 base ticks: 1 -> 1 MHz .. 15 -> 125 kHz
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= TLSC_L_IDLE;
      phase_ff <= 4'h0;
      left_ff  <= 8'h00;
      div_ff   <= 4'h1;
      out_ff   <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        TLSC_L_IDLE: begin
          out_ff <= 1'b0;
          if (start) begin
            // a zero count or the reserved divider code launches nothing
            if (eff_count == 8'h00 || freq_div == 4'h0) begin
              done_ff <= 1'b1;
            end else begin
              state_ff <= TLSC_L_RUN;
              left_ff  <= eff_count;
              div_ff   <= freq_div;
              phase_ff <= 4'h0;
            end
          end
        end
        TLSC_L_RUN: begin
          if (base_tick) begin
            out_ff <= (phase_ff < 4'((div_ff + 5'h01) >> 1));
            if (phase_ff == div_ff) begin
              phase_ff <= 4'h0;
              left_ff  <= left_ff - 8'h01;
              if (left_ff == 8'h01) begin
                state_ff <= TLSC_L_IDLE;
                done_ff  <= 1'b1;
              end
            end else begin
              phase_ff <= phase_ff + 4'h1;
            end
          end
        end
        default: state_ff <= TLSC_L_IDLE;
      endcase
    end
  end

  assign launch_out  = out_ff;
  assign launch_busy = (state_ff == TLSC_L_RUN);
  assign launch_done = done_ff;

endmodule
`default_nettype wire

// ---- rtl/tlsc_top.sv ----
// launch and stop configuration registers with stop-hit measurement control
`timescale 1ns/100ps
`default_nettype none
module tlsc_top
  import tlsc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_opcode,
  input  wire logic [15:0] cmd_wdata,
  output logic [15:0]      rd_data,
  output logic             rd_valid,
  output logic             cmd_unknown,
  input  wire logic        meas_start,
  input  wire logic        comp_in,
  input  wire logic [2:0]  result_sel,
  output logic             launch_out,
  output logic             meas_busy,
  output logic             stop_hit,
  output logic             second_ref_hit,
  output logic             results_write,
  output logic [15:0]      result_time,
  output logic [3:0]       hit_count,
  output logic [2:0]       measure_cycle_setting,
  output logic [2:0]       measure_timeout_setting
);

  typedef enum logic [1:0] {
    TLSC_IDLE   = 2'b00,
    TLSC_LISTEN = 2'b01,
    TLSC_DONE   = 2'b10
  } tlsc_state_type;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // stop-hit code to number of hits
  function automatic logic [3:0] hits_of(input logic [2:0] code);
    logic [3:0] n;
    n = {1'b0, code} + 4'h1;
    hits_of = (n > MAX_HITS) ? MAX_HITS : n;
  endfunction

  // wave select code to wave number
  function automatic logic [5:0] wave_of(input logic [5:0] code);
    wave_of = (code < MIN_WAVE + 6'h01) ? MIN_WAVE : code;
  endfunction

  logic [15:0]    pulse_launch_config_ff;
  logic [15:0]    stop_hit_config_ff;
  logic [15:0]    rd_data_ff;
  logic           rd_valid_ff;
  logic           unknown_ff;
  logic           comp_prev_ff;
  logic           stop_edge;
  logic           stop_edge_polarity;
  tlsc_state_type state_ff;
  logic [15:0]    tdc_cnt_ff;
  logic [3:0]     hit_cnt_ff;
  logic [5:0]     wave_cnt_ff;
  logic [3:0]     target_ff;
  logic [5:0]     wave_sel_ff;
  logic [15:0]    hit_time_ff [0:5];
  logic [15:0]    result_ff;
  logic           stop_hit_ff;
  logic           t2_hit_ff;
  logic           results_ff;
  logic           launch_start;
  logic           is_known;

  // ----------------------------------------------------------------
  // register access by opcode
  // ----------------------------------------------------------------
  assign is_known = (cmd_opcode == OPC_WR_PULSE) || (cmd_opcode == OPC_RD_PULSE)
                 || (cmd_opcode == OPC_WR_STOP)  || (cmd_opcode == OPC_RD_STOP);

  // reserved bits are not stored so they always read back zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_launch_config_ff <= PULSE_CFG_RST;
      stop_hit_config_ff     <= STOP_CFG_RST;
    end else if (cmd_valid) begin
      if (cmd_opcode == OPC_WR_PULSE) begin
        pulse_launch_config_ff <= cmd_wdata & PULSE_CFG_MASK;
      end
      if (cmd_opcode == OPC_WR_STOP) begin
        stop_hit_config_ff <= cmd_wdata & STOP_CFG_MASK;
      end
    end
  end

  // read answer one cycle after the opcode; unknown opcodes read zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_ff  <= 16'h0000;
      rd_valid_ff <= 1'b0;
      unknown_ff  <= 1'b0;
    end else begin
      rd_valid_ff <= cmd_valid && (cmd_opcode == OPC_RD_PULSE || cmd_opcode == OPC_RD_STOP);
      unknown_ff  <= cmd_valid && !is_known;
      if (cmd_valid && cmd_opcode == OPC_RD_PULSE) begin
        rd_data_ff <= pulse_launch_config_ff;
      end else if (cmd_valid && cmd_opcode == OPC_RD_STOP) begin
        rd_data_ff <= stop_hit_config_ff;
      end else if (cmd_valid) begin
        rd_data_ff <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // stop comparator slope select
  // ----------------------------------------------------------------
  assign stop_edge_polarity = pulse_launch_config_ff[POL_BIT];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      comp_prev_ff <= 1'b0;
    end else begin
      comp_prev_ff <= comp_in;
    end
  end

  // rising slope when polarity is 0, falling slope when it is 1
  assign stop_edge = stop_edge_polarity ? (comp_prev_ff && !comp_in)
                              : (!comp_prev_ff && comp_in);

  // ----------------------------------------------------------------
  // measurement sequence
  // ----------------------------------------------------------------
  assign launch_start = meas_start && (state_ff != TLSC_LISTEN);

  // settings are latched at start so a mid-measurement write cannot
  // change the hit target under a running count
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= TLSC_IDLE;
      tdc_cnt_ff  <= 16'h0000;
      hit_cnt_ff  <= 4'h0;
      wave_cnt_ff <= 6'h00;
      target_ff   <= 4'h1;
      wave_sel_ff <= MIN_WAVE;
      stop_hit_ff <= 1'b0;
      t2_hit_ff   <= 1'b0;
      results_ff  <= 1'b0;
    end else begin
      stop_hit_ff <= 1'b0;
      t2_hit_ff   <= 1'b0;
      results_ff  <= 1'b0;
      case (state_ff)
        TLSC_IDLE, TLSC_DONE: begin
          if (launch_start) begin
            state_ff    <= TLSC_LISTEN;
            tdc_cnt_ff  <= 16'h0000;
            hit_cnt_ff  <= 4'h0;
            wave_cnt_ff <= 6'h00;
            target_ff   <= hits_of(stop_hit_config_ff[HITS_MSB:HITS_LSB]);
            wave_sel_ff <= wave_of(stop_hit_config_ff[WAVE_MSB:WAVE_LSB]);
          end
        end
        TLSC_LISTEN: begin
          // saturating count: an over-range measurement ends without results
          if (tdc_cnt_ff == 16'hFFFF) begin
            state_ff <= TLSC_IDLE;
          end else begin
            tdc_cnt_ff <= tdc_cnt_ff + 16'h0001;
          end
          if (stop_edge && tdc_cnt_ff != 16'hFFFF) begin
            stop_hit_ff <= 1'b1;
            if (wave_cnt_ff != 6'h3F) begin
              wave_cnt_ff <= wave_cnt_ff + 6'h01;
            end
            if (wave_cnt_ff + 6'h01 == wave_sel_ff) begin
              t2_hit_ff <= 1'b1;
            end
            hit_cnt_ff <= hit_cnt_ff + 4'h1;
            if (hit_cnt_ff + 4'h1 == target_ff) begin
              state_ff   <= TLSC_DONE;
              results_ff <= 1'b1;
            end
          end
        end
        default: state_ff <= TLSC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // hit time store and result read
  // ----------------------------------------------------------------
  // times are only presented once the full set is in
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 6; i++) begin
        hit_time_ff[i] <= 16'h0000;
      end
    end else if (state_ff == TLSC_LISTEN && stop_edge && hit_cnt_ff < MAX_HITS) begin
      hit_time_ff[hit_cnt_ff[2:0]] <= tdc_cnt_ff;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      result_ff <= 16'h0000;
    end else if (state_ff == TLSC_DONE && {1'b0, result_sel} < target_ff) begin
      result_ff <= hit_time_ff[result_sel];
    end else begin
      result_ff <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // launcher
  // ----------------------------------------------------------------
  tlsc_launcher u_launcher (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .start       (launch_start),
    .pulse_count (pulse_launch_config_ff[PCOUNT_MSB:PCOUNT_LSB]),
    .freq_div    (pulse_launch_config_ff[FDIV_MSB:FDIV_LSB]),
    .launch_out  (launch_out),
    .launch_busy (),
    .launch_done ()
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_data                 = rd_data_ff;
  assign rd_valid                = rd_valid_ff;
  assign cmd_unknown             = unknown_ff;
  assign meas_busy               = (state_ff == TLSC_LISTEN);
  assign stop_hit                = stop_hit_ff;
  assign second_ref_hit          = t2_hit_ff;
  assign results_write           = results_ff;
  assign result_time             = result_ff;
  assign hit_count               = hit_cnt_ff;
  assign measure_cycle_setting   = stop_hit_config_ff[CYC_MSB:CYC_LSB];
  assign measure_timeout_setting = stop_hit_config_ff[TMO_MSB:TMO_LSB];

endmodule
`default_nettype wire

// ---- testbench/tlsc_host_model.sv ----
// host model issuing decoded opcode frames to the configuration block
`timescale 1ns/100ps
`default_nettype none
module tlsc_host_model
  import tlsc_pkg::*;
(
  input  wire logic core_clk,
  output logic      cmd_valid,
  output logic [7:0]  cmd_opcode,
  output logic [15:0] cmd_wdata
);
  initial begin
    cmd_valid  = 1'b0;
    cmd_opcode = 8'h00;
    cmd_wdata  = 16'h0000;
  end
  // one frame per call; idle lines inverted so stale values never look valid
  task automatic xfer(input logic [7:0] op, input logic [15:0] data);
    logic [15:0] d;
    d = data;
    if (op == OPC_WR_PULSE && d[FDIV_MSB:FDIV_LSB] == 4'h0) d[FDIV_LSB] = 1'b1;
    @(posedge core_clk);
    cmd_valid  <= 1'b1;
    cmd_opcode <= op;
    cmd_wdata  <= d;
    @(posedge core_clk);
    cmd_valid  <= 1'b0;
    cmd_opcode <= ~op;
    cmd_wdata  <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tlsc_top_properties.sv ----
// concurrent checks on the ports of the configuration block
`timescale 1ns/100ps
`default_nettype none
module tlsc_top_properties
  import tlsc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_opcode,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] rd_data,
  input wire logic        rd_valid,
  input wire logic        cmd_unknown,
  input wire logic        meas_start,
  input wire logic        meas_busy,
  input wire logic        stop_hit,
  input wire logic        second_ref_hit,
  input wire logic        results_write,
  input wire logic [3:0]  hit_count
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // request shapes reused below
  sequence s_rd_pulse; cmd_valid && cmd_opcode == OPC_RD_PULSE; endsequence
  sequence s_rd_stop; cmd_valid && cmd_opcode == OPC_RD_STOP; endsequence
  sequence s_wr_pulse; cmd_valid && cmd_opcode == OPC_WR_PULSE; endsequence
  sequence s_wr_then_rd; s_wr_pulse ##1 !cmd_valid ##1 s_rd_pulse; endsequence
  logic known;
  assign known = cmd_opcode inside {OPC_WR_PULSE, OPC_RD_PULSE, OPC_WR_STOP, OPC_RD_STOP};
  a_read_answer: assert property (s_rd_pulse or s_rd_stop |=> rd_valid && !cmd_unknown)
    else $error("read gave no answer");
  a_unknown_flag: assert property (cmd_valid && !known |=> cmd_unknown && !rd_valid)
    else $error("unknown opcode not flagged");
  a_idle_quiet: assert property (!cmd_valid |=> !rd_valid && !cmd_unknown && $stable(rd_data))
    else $error("answer without request");
  a_pulse_reserved: assert property (s_rd_pulse |=> rd_data[2:0] == 3'h0)
    else $error("reserved pulse bits read nonzero");
  a_write_read_back: assert property (s_wr_then_rd |=> rd_data == ($past(cmd_wdata, 3) & PULSE_CFG_MASK))
    else $error("pulse register read back wrong");
  a_hits_bounded: assert property (hit_count <= MAX_HITS)
    else $error("hit count above six");
  a_results_last: assert property (results_write |-> stop_hit && !meas_busy)
    else $error("results written off the final hit");
  a_second_on_hit: assert property (second_ref_hit |-> stop_hit)
    else $error("second reference without a hit");
  a_start_listen: assert property (meas_start && !meas_busy |=> meas_busy)
    else $error("start did not begin listening");
  a_hit_while_busy: assert property (stop_hit |-> $past(meas_busy))
    else $error("hit outside a measurement");
endmodule
bind tlsc_top tlsc_top_properties u_props (.core_clk(core_clk), .rstn(rstn),
  .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_wdata(cmd_wdata),
  .rd_data(rd_data), .rd_valid(rd_valid), .cmd_unknown(cmd_unknown),
  .meas_start(meas_start), .meas_busy(meas_busy), .stop_hit(stop_hit),
  .second_ref_hit(second_ref_hit), .results_write(results_write), .hit_count(hit_count));
`default_nettype wire

// ---- testbench/tb_tlsc_top.sv ----
// self-checking bench for the launch and stop configuration block
`timescale 1ns/100ps
`default_nettype none
module tb_tlsc_top;
  import tlsc_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, meas_start = 1'b0, comp_in = 1'b0;
  logic cmd_valid, rd_valid, cmd_unknown, launch_out, meas_busy;
  logic stop_hit, second_ref_hit, results_write;
  logic [7:0] cmd_opcode;
  logic [15:0] cmd_wdata, rd_data, result_time;
  logic [3:0] hit_count;
  logic [2:0] cyc_set, tmo_set;
  logic [2:0] result_sel = 3'h0;
  int failures = 0, checked = 0, cycles = 0, f0, f1;
  always #12.5 core_clk = ~core_clk;
  tlsc_host_model u_host (.core_clk(core_clk), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .cmd_wdata(cmd_wdata));
  tlsc_top DUT (.core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
    .cmd_unknown(cmd_unknown), .meas_start(meas_start), .comp_in(comp_in),
    .result_sel(result_sel), .launch_out(launch_out), .meas_busy(meas_busy), .stop_hit(stop_hit),
    .second_ref_hit(second_ref_hit), .results_write(results_write),
    .result_time(result_time), .hit_count(hit_count),
    .measure_cycle_setting(cyc_set), .measure_timeout_setting(tmo_set));
  task automatic results;
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // hang guard: whole run needs about 19000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      results();
    end
  end
  task automatic rd(input logic [7:0] op, input logic [15:0] exp);
    u_host.xfer(op, 16'h0000);
    #1;
    check({15'h0, rd_valid}, 16'h0001);
    check(rd_data, exp);
  endtask
  task automatic pulse_start;
    @(posedge core_clk);
    meas_start <= 1'b1;
    @(posedge core_clk);
    meas_start <= 1'b0;
  endtask
  // registers: reset values, reserved bits, side outputs, unknown opcode
  task automatic regs;
    rd(OPC_RD_PULSE, 16'h0000);
    rd(OPC_RD_STOP, 16'h0000);
    u_host.xfer(OPC_WR_PULSE, 16'hFFFF);
    rd(OPC_RD_PULSE, 16'hFFF8);
    u_host.xfer(OPC_WR_STOP, 16'hFFFF);
    rd(OPC_RD_STOP, 16'hFFF7);
    u_host.xfer(OPC_WR_STOP, 16'h0052);
    // register only settles in the step after the taking edge
    #1;
    check({10'h0, cyc_set, tmo_set}, 16'h002A);
    u_host.xfer(8'h12, 16'h0000);
    #1;
    check({15'h0, cmd_unknown}, 16'h0001);
    check(rd_data, 16'h0000);
  endtask
  // one measurement with a square wave of period 8 on the comparator
  task automatic meas(input logic [2:0] code, input logic pol, input logic [5:0] wave,
                      output int first);
    int hits, writes, ref_at, t, eh, ew;
    u_host.xfer(OPC_WR_PULSE, {8'h00, 4'h1, pol, 3'h0});
    u_host.xfer(OPC_WR_STOP, {code, wave, 7'h00});
    pulse_start();
    hits = 0; writes = 0; ref_at = 0; first = 0;
    for (t = 0; t < 100; t++) begin
      @(posedge core_clk);
      comp_in <= t[2];
      #1;
      if (stop_hit === 1'b1) hits++;
      if (stop_hit === 1'b1 && hits == 1) first = t;
      if (second_ref_hit === 1'b1) ref_at = hits;
      if (results_write === 1'b1) writes++;
    end
    eh = (code > 3'h5) ? 6 : code + 1;
    ew = (wave < 6'h03) ? 2 : wave;
    check(16'(hits), 16'(eh));
    check({12'h0, hit_count}, 16'(eh));
    check(16'(writes), 16'h0001);
    check(16'(ref_at), (ew <= eh) ? 16'(ew) : 16'h0000);
    check({15'h0, meas_busy}, 16'h0000);
    // last stored hit time, one edge per slope period after the first; beyond target reads 0
    @(posedge core_clk);
    result_sel <= 3'(eh - 1);
    @(posedge core_clk);
    result_sel <= 3'(eh);
    #1;
    check(result_time, 16'(first + 8 * (eh - 1)));
    @(posedge core_clk);
    #1;
    check(result_time, 16'h0000);
  endtask
  // launch burst: count rising edges and the spacing of the first two
  task automatic launch(input logic [7:0] cnt, input logic [3:0] div, input int en, input int ep);
    int n, t1, t2, t;
    logic prev;
    u_host.xfer(OPC_WR_STOP, 16'h0000);
    u_host.xfer(OPC_WR_PULSE, {cnt, div, 4'h0});
    pulse_start();
    n = 0; t1 = 0; t2 = 0; prev = 1'b0;
    for (t = 0; t < 6000; t++) begin
      @(posedge core_clk);
      comp_in <= (t == 10); // single rise ends listening early
      #1;
      if (launch_out === 1'b1 && prev === 1'b0) n++;
      if (launch_out === 1'b1 && prev === 1'b0 && n == 1) t1 = t;
      if (launch_out === 1'b1 && prev === 1'b0 && n == 2) t2 = t;
      prev = launch_out;
    end
    check(16'(n), 16'(en));
    if (en > 1) check(16'(t2 - t1), 16'(ep));
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    regs();
    for (int c = 0; c < 8; c++) begin
      meas(3'(c), 1'b0, (c == 7) ? 6'h3F : 6'(c), f1);
      if (c == 5) f0 = f1;
    end
    meas(3'h5, 1'b1, 6'h05, f1);
    check(16'(f1 - f0), 16'h0004);
    launch(8'hFF, 4'h1, 127, 40);
    launch(8'h02, 4'hF, 2, 320);
    launch(8'h00, 4'h3, 0, 0);
    results();
  end
endmodule
`default_nettype wire
